// file: dqm_pkg.sv
/*
  Shared constants and types for the slot-to-container mapper.
  Assumes a single 100 MHz core clock; all cycle counts derive from it.
*/
package dqm_pkg;
  // ==========================================================
  // Clocking and container timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FRAME_NS = 125000;
  localparam int unsigned FRAME_CYCLES = FRAME_NS / CLK_PERIOD_NS;
  localparam logic [3:0] VC4_ROWS = 4'h9;
  localparam logic [8:0] VC4_COLS = 9'h105;
  localparam logic [15:0] VC4_OCTETS = 16'h092D;
  // ==========================================================
  // Path overhead rows in the first column
  localparam logic [3:0] ROW_C2 = 4'h2;
  localparam logic [3:0] ROW_F2 = 4'h4;
  localparam logic [3:0] ROW_H4 = 4'h5;
  localparam logic [3:0] ROW_F3 = 4'h6;
  localparam logic [7:0] C2_LABEL = 8'h14;
  localparam logic [7:0] POH_IDLE = 8'h00;
  // ==========================================================
  // Slot layout
  localparam logic [5:0] SLOT_LEN = 6'h35;
  localparam logic [5:0] HDR_LEN = 6'h05;
  localparam logic [5:0] HCS_IDX = 6'h04;
  localparam logic [7:0] HCS_MASK = 8'h55;
  localparam logic [7:0] VOID_OCTET = 8'h00;
  localparam int unsigned SCR_LEN = 43;
  // ==========================================================
  // Octet type marker codes
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_START = 2'h1;
  localparam logic [1:0] KIND_M1 = 2'h2;
  localparam logic [1:0] KIND_M2 = 2'h3;
  // ==========================================================
  // Link status codes
  localparam logic [1:0] LSS_CONNECTED = 2'h0;
  localparam logic [1:0] LSS_LINK_UP = 2'h1;
  localparam logic [1:0] LSS_HOB_INCAP = 2'h2;
  localparam logic [1:0] LSS_LINK_DOWN = 2'h3;
  // ==========================================================
  // Octet buffer
  localparam int unsigned FIFO_AW = 7;
  localparam int unsigned PTR_W = FIFO_AW + 1;
  localparam logic [PTR_W-1:0] FIFO_DEPTH = 8'h80;
  localparam logic [PTR_W-1:0] DISCARD_MIN = 8'h02;

  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] data;
  } dqm_octet_t;

  typedef struct packed {
    logic valid;
    dqm_octet_t oct;
  } dqm_client_t;

  typedef struct packed {
    logic [7:0] data;
    logic strobe;
    logic fs;
    logic drive;
  } dqm_ai_t;
endpackage

// file: dqm_octet_ram.sv
/*
  Octet store for the client buffer: one write port, registered read.
  Assumes reads are held steady for two cycles before the data is used.
*/
`timescale 1ns/1ns
module dqm_octet_ram
  import dqm_pkg::*;
(
  input wire logic mclk_i, // Core clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic we_i, // Write strobe
  input wire logic [FIFO_AW-1:0] waddr_i, // Write address
  input wire dqm_octet_t wdata_i, // Write octet
  input wire logic [FIFO_AW-1:0] raddr_i, // Read address
  output dqm_octet_t rdata_o // Registered read octet
);
  // ==========================================================
  // Storage
  dqm_octet_t mem [0:(1<<FIFO_AW)-1];

  // Array write, no reset needed on contents
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Read data always from a register
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

// file: dqm_scrambler.sv
/*
  Self-synchronous x^43+1 scrambler, one octet per advance, MSB first.
  Assumes the caller raises advance only for slot payload octets.
*/
`timescale 1ns/1ns
module dqm_scrambler
  import dqm_pkg::*;
(
  input wire logic mclk_i, // Core clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic advance_i, // Commit one octet
  input wire logic [7:0] din_i, // Plain octet
  output logic [7:0] dout_o // Scrambled octet
);
  // ==========================================================
  // State: history of scrambled output bits
  typedef struct packed {
    logic [SCR_LEN-1:0] hist;
  } dqm_scr_state_t;

  dqm_scr_state_t st_reg;
  dqm_scr_state_t st_next;

  // Bit-serial unroll; state is frozen unless advanced
  always_comb begin
    logic [SCR_LEN-1:0] h;
    h = st_reg.hist;
    dout_o = '0;
    for (int i = 7; i >= 0; i--) begin
      dout_o[i] = din_i[i] ^ h[SCR_LEN-1];
      h = {h[SCR_LEN-2:0], dout_o[i]};
    end
    st_next = st_reg;
    if (advance_i) begin
      st_next.hist = h;
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// file: dqm_mapper.sv
/*
  Maps client slots and management octets into a container byte stream,
  adding C2, H4, F2 and F3, with void slots when client data runs short.
  Assumes the client clock is slow (about 125 ns) and data changes away
  from its rising edge; all client pins are synchronised here.
*/
// Operation
// - Slots placed row-wise, may cross frames
// - Type marker flags slot start, M1, M2
// - Validity flag gates each client octet
// - Scramble 48 payload octets, not header
// - Scrambler frozen outside slot payload
// - Self-synchronous scrambler, polynomial x^43 + 1
// - HCS octet XORed with 01010101
// - M1 into F2, M2 into F3
// - Add C2 and H4, fixed frame start
// - Link status code in H4 bits 1-2
// - Status codes 00, 11, 01, 10
// - H4 bits 3-8 hold slot offset
// - Slot offset always within 0 to 52
// - C2 carries label 0001 0100
// - Drive output only while activated
// - Void zero slots when client data missing
// - Insert received link status into H4
`timescale 1ns/1ns
module dqm_mapper
  import dqm_pkg::*;
#(
  parameter int unsigned FRAME_LEN = FRAME_CYCLES
) (
  input wire logic mclk_i, // Core clock, 100 MHz
  input wire logic resetn_i, // Async reset, active low
  input wire logic client_clock_i, // Client octet clock
  input wire logic [7:0] client_octet_stream_i, // Client octet
  input wire logic [1:0] octet_type_marker_i, // Data/start/M1/M2
  input wire logic octet_validity_i, // High when octet valid
  input wire logic [1:0] remote_link_status_in_i, // Status to send
  input wire logic activation_control_i, // Enable output
  output logic [7:0] container_output_data_o, // Container octet
  output logic container_octet_strobe_o, // Octet valid pulse
  output logic container_frame_start_o, // First octet of frame
  output logic container_drive_o, // Access point driven
  output logic void_slot_o, // Current slot is void
  output logic overflow_o // Sticky buffer overflow
);
  // ==========================================================
  // State record
  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    dqm_client_t cli_s1;
    dqm_client_t cli_s2;
    logic act_s1;
    logic act_s2;
    logic [1:0] lss_s1;
    logic [1:0] lss_s2;
    logic [15:0] acc;
    logic [3:0] row;
    logic [8:0] col;
    logic [5:0] slot_pos;
    logic slot_real;
    logic [7:0] m1;
    logic [7:0] m2;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    dqm_ai_t ai;
    logic void_slot;
    logic overflow;
  } dqm_state_t;

  dqm_state_t st_reg;
  dqm_state_t st_next;

  // ==========================================================
  // Internal strobes
  logic capture;
  logic tick;
  logic wr_en;
  logic pop;
  logic scr_adv;
  logic real_now;
  logic full;
  logic [PTR_W-1:0] count;
  logic [15:0] acc_sum;
  logic [5:0] offset;
  logic [7:0] payload_oct;
  dqm_octet_t head;
  logic [7:0] scr_out;

  // ==========================================================
  // Client octet store, crossing from client pace to container pace
  dqm_octet_ram u_ram (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .we_i(wr_en),
    .waddr_i(st_reg.wr_ptr[FIFO_AW-1:0]),
    .wdata_i(st_reg.cli_s2.oct),
    .raddr_i(st_reg.rd_ptr[FIFO_AW-1:0]),
    .rdata_o(head)
  );

  // ==========================================================
  // Payload scrambler
  dqm_scrambler u_scr (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .advance_i(scr_adv),
    .din_i(head.data),
    .dout_o(scr_out)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    capture = 1'b0;
    tick = 1'b0;
    wr_en = 1'b0;
    pop = 1'b0;
    scr_adv = 1'b0;
    real_now = st_reg.slot_real;
    payload_oct = VOID_OCTET;
    acc_sum = '0;

    // Two-stage synchronisers; stage one read only by stage two
    st_next.clk_s1 = client_clock_i;
    st_next.clk_s2 = st_reg.clk_s1;
    st_next.clk_s3 = st_reg.clk_s2;
    st_next.cli_s1 = {octet_validity_i, octet_type_marker_i, client_octet_stream_i};
    st_next.cli_s2 = st_reg.cli_s1;
    st_next.act_s1 = activation_control_i;
    st_next.act_s2 = st_reg.act_s1;
    st_next.lss_s1 = remote_link_status_in_i;
    st_next.lss_s2 = st_reg.lss_s1;

    // Rising client clock edge; data path shares the sync delay
    capture = st_reg.clk_s2 & ~st_reg.clk_s3;
    count = st_reg.wr_ptr - st_reg.rd_ptr;
    full = (count == FIFO_DEPTH);

    // Offset from H4 to the next slot start, 0..52
    offset = (st_reg.slot_pos == '0) ? 6'h00 : (SLOT_LEN - st_reg.slot_pos);

    // Client side: invalid octets never enter the store
    if (capture && st_reg.cli_s2.valid) begin
      unique case (st_reg.cli_s2.oct.kind)
        KIND_M1: begin
          st_next.m1 = st_reg.cli_s2.oct.data;
        end
        KIND_M2: begin
          st_next.m2 = st_reg.cli_s2.oct.data;
        end
        KIND_DATA, KIND_START: begin
          if (full) begin
            st_next.overflow = 1'b1; // Lost octet, slot will resync
          end else begin
            wr_en = 1'b1;
          end
        end
      endcase
    end
    if (wr_en) begin
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end

    // Fractional octet pacing: exactly VC4_OCTETS ticks per frame
    acc_sum = st_reg.acc + VC4_OCTETS;
    if (acc_sum >= 16'(FRAME_LEN)) begin
      tick = 1'b1;
      st_next.acc = acc_sum - 16'(FRAME_LEN);
    end else begin
      st_next.acc = acc_sum;
    end

    // Output strobes last one cycle
    st_next.ai.strobe = 1'b0;
    st_next.ai.fs = 1'b0;
    st_next.ai.drive = st_reg.act_s2;

    if (tick) begin
      st_next.ai.strobe = st_reg.act_s2;
      st_next.ai.fs = st_reg.act_s2 && (st_reg.row == '0) && (st_reg.col == '0);

      if (st_reg.col == '0) begin
        // Path overhead column; unowned bytes stay idle
        unique case (st_reg.row)
          ROW_C2: st_next.ai.data = C2_LABEL;
          ROW_F2: st_next.ai.data = st_reg.m1;
          ROW_H4: st_next.ai.data = {st_reg.lss_s2, offset};
          ROW_F3: st_next.ai.data = st_reg.m2;
          default: st_next.ai.data = POH_IDLE;
        endcase
      end else begin
        // Slot start decision needs a whole slot already buffered
        if (st_reg.slot_pos == '0) begin
          real_now = (count >= PTR_W'(SLOT_LEN)) && (head.kind == KIND_START);
          st_next.slot_real = real_now;
        end
        if (real_now) begin
          pop = 1'b1;
          if (st_reg.slot_pos == HCS_IDX) begin
            payload_oct = head.data ^ HCS_MASK;
          end else if (st_reg.slot_pos < HDR_LEN) begin
            payload_oct = head.data;
          end else begin
            scr_adv = 1'b1;
            payload_oct = scr_out;
          end
        end else begin
          // Void octet; meanwhile drop stray octets to regain slot start
          payload_oct = VOID_OCTET;
          if ((count >= DISCARD_MIN) && (head.kind != KIND_START)) begin
            pop = 1'b1;
          end
        end
        st_next.ai.data = payload_oct;
        st_next.void_slot = ~real_now;
        // Slot counter runs on across frame edges
        if (st_reg.slot_pos == SLOT_LEN - 6'h01) begin
          st_next.slot_pos = '0;
        end else begin
          st_next.slot_pos = st_reg.slot_pos + 6'h01;
        end
      end

      // Row-major walk over the container
      if (st_reg.col == VC4_COLS - 9'h001) begin
        st_next.col = '0;
        if (st_reg.row == VC4_ROWS - 4'h1) begin
          st_next.row = '0;
        end else begin
          st_next.row = st_reg.row + 4'h1;
        end
      end else begin
        st_next.col = st_reg.col + 9'h001;
      end

    end

    // Quiet data on every cycle, not only at ticks, so it drops with drive
    if (!st_reg.act_s2) begin
      st_next.ai.data = '0;
    end

    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs come straight from the state register
  assign container_output_data_o = st_reg.ai.data;
  assign container_octet_strobe_o = st_reg.ai.strobe;
  assign container_frame_start_o = st_reg.ai.fs;
  assign container_drive_o = st_reg.ai.drive;
  assign void_slot_o = st_reg.void_slot;
  assign overflow_o = st_reg.overflow;
endmodule

// file: dqm_mapper_checker.sv
/*
  Port checker for the slot mapper: frame timing, overhead bytes, activation.
  Assumes a bind onto dqm_mapper that hands FRAME_LEN on.
*/
`timescale 1ns/1ns
module dqm_mapper_checker
  import dqm_pkg::*;
#(
  parameter int unsigned FRAME_LEN = FRAME_CYCLES
) (
  input wire logic mclk_i, // Core clock
  input wire logic resetn_i, // Reset, active low
  input wire logic [1:0] remote_link_status_in_i, // Status in
  input wire logic activation_control_i, // Enable in
  input wire logic [7:0] container_output_data_o, // Octet out
  input wire logic container_octet_strobe_o, // Octet strobe
  input wire logic container_frame_start_o, // Frame start
  input wire logic container_drive_o // Drive enable
);
  // ==========================================
  // Helpers
  logic [11:0] cnt_reg, cur;
  logic [15:0] gap_reg;
  logic [3:0] calm_reg;
  logic seen_reg, stb, fs, h4;
  logic [7:0] d;
  assign d = container_output_data_o;
  assign fs = container_frame_start_o;
  assign cur = fs ? 12'h000 : cnt_reg;
  assign stb = container_octet_strobe_o & seen_reg;
  assign h4 = stb && cur == 12'h519;
  // Positions are trusted only after a frame start seen while driving
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 12'h000;
      gap_reg <= 16'h0000;
      calm_reg <= 4'h0;
      seen_reg <= 1'b0;
    end else begin
      cnt_reg <= container_octet_strobe_o ? cur + 12'h001 : cnt_reg;
      gap_reg <= fs ? 16'h0001 : gap_reg + 16'h0001;
      calm_reg <= $stable(remote_link_status_in_i) ? calm_reg + {3'h0, calm_reg != 4'hF} : 4'h0;
      seen_reg <= container_drive_o & (seen_reg | fs);
    end
  end
  // ==========================================
  // Assertions
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence drive_on;
    ##[1:4] container_drive_o;
  endsequence
  frame_gap_a: assert property (fs && seen_reg |-> gap_reg == 16'(FRAME_LEN))
    else $error("frame start spacing wrong");
  frame_octets_a: assert property (fs && seen_reg |-> cnt_reg == VC4_OCTETS[11:0])
    else $error("octets per frame wrong");
  fs_strobe_a: assert property (fs |-> container_octet_strobe_o)
    else $error("frame start without octet");
  c2_label_a: assert property (stb && cur == 12'h20A |-> d == C2_LABEL)
    else $error("signal label wrong");
  h4_range_a: assert property (h4 |-> d[5:0] <= 6'h34)
    else $error("slot offset out of range");
  h4_status_a: assert property (h4 && calm_reg == 4'hF |-> d[7:6] == remote_link_status_in_i)
    else $error("link status not inserted");
  poh_idle_a: assert property (stb && cur % 12'h105 == 12'h000 &&
    !(cur inside {12'h20A, 12'h414, 12'h519, 12'h61E}) |-> d == POH_IDLE)
    else $error("unused overhead not idle");
  idle_quiet_a: assert property (!container_drive_o |-> !container_octet_strobe_o && d == 8'h00)
    else $error("output active while off");
  drive_up_a: assert property ($rose(activation_control_i) |-> drive_on)
    else $error("drive did not follow");
endmodule

// file: dqm_client_model.sv
/*
  Client model: M1, M2 and a numbered 53-octet slot, repeated while enabled.
  Assumes mode_i: 0 idle, 1 valid octets, 2 octets marked invalid.
*/
`timescale 1ns/1ns
module dqm_client_model
  import dqm_pkg::*;
(
  input wire logic [1:0] mode_i, // Traffic mode
  output logic clk_o, // Client clock
  output logic [7:0] data_o, // Client octet
  output logic [1:0] kind_o, // Octet type marker
  output logic valid_o // Octet validity
);
  // ==========================================
  // Slot content: fixed header, payload octet i holds i
  function automatic logic [7:0] octet_at(input logic [5:0] i);
    logic [39:0] hdr;
    hdr = 40'h5AA53CC30F;
    return (i < HDR_LEN) ? hdr[8 * (HDR_LEN - 6'h01 - i) +: 8] : {2'h0, i};
  endfunction
  // One octet, set while the clock is low; invalid ones carry inverted data
  task automatic put(input logic [1:0] k, input logic [7:0] d, input logic v);
    kind_o = k;
    valid_o = v;
    data_o = v ? d : ~d;
    #62 clk_o = 1'b1;
    #63 clk_o = 1'b0;
  endtask
  // Clock stands still when idle; data keeps changing so nothing stale lingers
  initial begin
    logic v;
    clk_o = 1'b0;
    data_o = 8'h00;
    kind_o = KIND_DATA;
    valid_o = 1'b0;
    forever begin
      v = (mode_i == 2'h1);
      if (mode_i == 2'h0) begin
        #37 data_o = ~data_o;
      end else begin
        put(KIND_M1, 8'hE1, v);
        put(KIND_M2, 8'h7E, v);
        for (int i = 0; i < 53; i++) begin
          put((i == 0) ? KIND_START : KIND_DATA, octet_at(6'(i)), v);
        end
      end
    end
  end
endmodule

// file: testbench.sv
/*
  Bench for the mapper: idle, status codes, valid and invalid slots, release.
  Assumes the client model drives the client pins and the checker is bound here.
*/
`timescale 1ns/1ns
module testbench;
  import dqm_pkg::*;
  localparam int unsigned FL = 4698;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic client_clock_i, octet_validity_i, container_octet_strobe_o, container_frame_start_o;
  logic container_drive_o, void_slot_o, overflow_o;
  logic full = 1'b0; // Void until a real slot start is seen
  logic [7:0] client_octet_stream_i, container_output_data_o, d, e, c2, f2, f3, h4;
  logic [1:0] octet_type_marker_i;
  logic [1:0] remote_link_status_in_i = 2'h0;
  logic activation_control_i = 1'b0;
  logic [1:0] mode = 2'h0;
  logic synced = 1'b0;
  logic [11:0] idx;
  logic [5:0] spos, sp;
  logic [42:0] hist = 43'h0;
  int error_cnt = 0;
  int comparisons = 0;
  int nreal = 0;
  int nstb = 0;
  int n0;
  // ==========================================
  // Clock and instances
  always #5 mclk_i = ~mclk_i;
  dqm_client_model dqm_client_model_i (.mode_i(mode), .clk_o(client_clock_i), .data_o(client_octet_stream_i),
    .kind_o(octet_type_marker_i), .valid_o(octet_validity_i));
  dqm_mapper #(.FRAME_LEN(FL)) dqm_mapper_i (.mclk_i, .resetn_i, .client_clock_i, .client_octet_stream_i,
    .octet_type_marker_i, .octet_validity_i, .remote_link_status_in_i, .activation_control_i,
    .container_output_data_o, .container_octet_strobe_o, .container_frame_start_o, .container_drive_o,
    .void_slot_o, .overflow_o);
  // ==========================================
  // Compare and close
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Monitor: overhead capture, slot tracking from H4, descrambling
  always @(posedge mclk_i) begin
    if (container_octet_strobe_o) begin
      d = container_output_data_o;
      nstb++;
      idx = container_frame_start_o ? 12'h000 : idx + 12'h001;
      if (idx % 261 == 0) begin
        case (idx / 261)
          2: c2 = d;
          4: f2 = d;
          6: f3 = d;
          5: begin
            h4 = d;
            sp = (d[5:0] == 6'h00) ? 6'h00 : 6'h35 - d[5:0];
            if (synced) begin
              check({2'h0, spos}, {2'h0, sp});
            end
            spos = sp;
            synced = 1'b1;
          end
          default: ;
        endcase
      end else if (synced) begin
        if (spos == 6'h00) begin
          full = (d !== VOID_OCTET);
          nreal += full;
        end
        if (!full) begin
          check(d, VOID_OCTET);
        end else if (spos < HDR_LEN) begin
          check(d, dqm_client_model_i.octet_at(spos) ^ ((spos == HCS_IDX) ? HCS_MASK : 8'h00));
        end else begin
          for (int b = 7; b >= 0; b--) begin
            e[b] = d[b] ^ hist[42];
            hist = {hist[41:0], d[b]};
          end
          check(e, dqm_client_model_i.octet_at(spos));
        end
        spos = (spos == 6'h34) ? 6'h00 : spos + 6'h01;
      end
    end
  end
  // Main sequence: inputs change at rising edges only
  initial begin
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (FL) @(posedge mclk_i);
    check(8'(nstb), 8'h00);
    check({7'h00, container_drive_o}, 8'h00);
    activation_control_i <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      remote_link_status_in_i <= 2'(k);
      repeat (2) @(posedge container_frame_start_o);
      check({6'h00, h4[7:6]}, {6'h00, 2'(k)});
    end
    check(c2, C2_LABEL);
    check({7'h00, void_slot_o}, 8'h01);
    mode <= 2'h1;
    repeat (3) @(posedge container_frame_start_o);
    check(f2, 8'hE1);
    check(f3, 8'h7E);
    check(8'(nreal > 10), 8'h01);
    mode <= 2'h2;
    @(posedge container_frame_start_o);
    n0 = nreal;
    repeat (2) @(posedge container_frame_start_o);
    check(8'(nreal - n0), 8'h00);
    check(f2, 8'hE1);
    check({7'h00, overflow_o}, 8'h00);
    activation_control_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    check({7'h00, container_drive_o}, 8'h00);
    results();
  end
  // Watchdog sized for about nineteen frames
  initial begin
    #900000;
    error_cnt++;
    results();
  end
endmodule
bind dqm_mapper dqm_mapper_checker #(.FRAME_LEN(FRAME_LEN)) dqm_mapper_checker_i (.mclk_i, .resetn_i,
  .remote_link_status_in_i, .activation_control_i, .container_output_data_o, .container_octet_strobe_o,
  .container_frame_start_o, .container_drive_o);
